/* card_sink.sv */
/* Card-side consumer that collects beats; slow mode stalls every other cycle.
   Assumes the bench reads its got queue. */
module card_sink (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic slow,
	input wire distributed_dma_cfg_pkg::card_beat_s card_beat,
	input wire logic card_beat_valid,
	output logic card_beat_ready
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] got[$];
	// ====================
	// Consumer.
	always @(posedge clk_sys) begin
		if (!rstn) begin
			card_beat_ready <= 1'b0;
		end else begin
			if (card_beat_valid && card_beat_ready) begin
				got.push_back(card_beat.data);
			end
			card_beat_ready <= slow ? !card_beat_ready : 1'b1;
		end
	end
endmodule : card_sink

/* distributed_dma_cfg_pkg.sv */
/*
 * Constants and carrier types for the distributed DMA configuration register bank.
 * Assumes a byte-addressed configuration port with 32-bit data and byte enables.
 */
package distributed_dma_cfg_pkg;

	// ==========================================================================
	// Register offsets (byte addresses in configuration space)
	// ==========================================================================
	localparam logic [7:0] socket_dma_control_0_off = 8'h94;
	localparam logic [7:0] socket_dma_control_1_off = 8'h98;
	localparam logic [7:0] capability_identifier_off = 8'ha0;
	localparam logic [7:0] next_capability_pointer_off = 8'ha1;

	// ==========================================================================
	// Fixed values and reset values
	// ==========================================================================
	localparam logic [7:0] capability_identifier_val = 8'h01;
	localparam logic [7:0] next_capability_pointer_val = 8'h00;
	localparam logic [11:0] distributed_dma_window_base_rst = 12'h000;
	localparam logic [1:0] card_transfer_width_rst = 2'h0;
	localparam logic distributed_dma_decode_enable_rst = 1'b0;
	localparam logic [1:0] dma_request_pin_select_rst = 2'h0;

	// ==========================================================================
	// Field positions
	// ==========================================================================
	localparam int base_lsb = 4;
	localparam int ext_bit = 3;
	localparam int width_lsb = 1;
	localparam int enable_bit = 0;

	// ==========================================================================
	// Encodings
	// ==========================================================================
	localparam logic [1:0] width_8bit = 2'h0;
	localparam logic [1:0] width_16bit = 2'h1;
	localparam logic [1:0] pin_none = 2'h0;
	localparam logic [1:0] pin_speaker = 2'h1;
	localparam logic [1:0] pin_io_is_16bit = 2'h2;
	localparam logic [1:0] pin_input_acknowledge = 2'h3;

	// Index of the last of the card transfers that drain one prefetched word, per width.
	localparam logic [1:0] last_beat_8bit = 2'h3;
	localparam logic [1:0] last_beat_16bit = 2'h1;

	// ==========================================================================
	// Carrier types
	// ==========================================================================
	typedef struct packed {
		logic [11:0] distributed_dma_window_base;
		logic [1:0] card_transfer_width;
		logic distributed_dma_decode_enable;
	} dma_control_1_s;

	typedef struct packed {
		logic [15:0] data;
		logic is_16bit;
	} card_beat_s;

endpackage : distributed_dma_cfg_pkg

/* distributed_dma_sva.sv */
/* Assertions on the ports of the DMA configuration bank.
   Assumes one clock, clk_sys, and synchronous active-low rstn. */
module distributed_dma_sva (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic [7:0] cfg_addr,
	input wire logic [31:0] cfg_wdata,
	input wire logic [3:0] cfg_byte_en,
	input wire logic cfg_write,
	input wire logic cfg_read,
	input wire logic [31:0] cfg_rdata,
	input wire logic [31:0] io_addr,
	input wire logic io_valid,
	input wire logic distributed_dma_hit,
	input wire logic [11:0] distributed_dma_window_base,
	input wire logic [1:0] card_transfer_width,
	input wire logic distributed_dma_decode_enable,
	input wire logic [1:0] dma_request_pin_select,
	input wire logic pci_word_valid,
	input wire logic pci_word_ready,
	input wire distributed_dma_cfg_pkg::card_beat_s card_beat,
	input wire logic card_beat_valid
);
	// ====================
	// Checks.
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	sequence s_load;
		pci_word_valid && pci_word_ready;
	endsequence
	sequence s_rd(w);
		cfg_read && cfg_addr[7:2] == w;
	endsequence
	a_hit_decode: assert property (
		distributed_dma_hit == (io_valid && distributed_dma_decode_enable && io_addr[31:16] == 16'h0
		&& io_addr[15:4] == distributed_dma_window_base)) else $error("window decode wrong");
	a_rdata_idle: assert property (
		!$past(cfg_read) |-> cfg_rdata == 32'h0) else $error("read data not idle");
	a_ctl_read: assert property (
		s_rd(6'h26) |=> cfg_rdata == {16'h0, distributed_dma_window_base, 1'b0, card_transfer_width,
		distributed_dma_decode_enable}) else $error("control read wrong");
	a_cap_read: assert property (
		s_rd(6'h28) |=> cfg_rdata == 32'h1) else $error("capability read wrong");
	a_ctl_write: assert property (
		cfg_write && cfg_addr[7:2] == 6'h26 && cfg_byte_en[0]
		|=> distributed_dma_decode_enable == $past(cfg_wdata[0])) else $error("enable not written");
	a_pin_write: assert property (
		cfg_write && cfg_addr[7:2] == 6'h25 && cfg_byte_en[0]
		|=> dma_request_pin_select == $past(cfg_wdata[1:0])) else $error("pin select not written");
	a_cfg_hold: assert property (
		!cfg_write |=> $stable(distributed_dma_window_base) && $stable(card_transfer_width)
		&& $stable(distributed_dma_decode_enable)) else $error("control changed");
	a_beat_width: assert property (
		card_beat_valid |-> card_beat.is_16bit == (card_transfer_width == 2'h1))
		else $error("beat width wrong");
	a_byte_upper: assert property (
		card_beat_valid && !card_beat.is_16bit |-> card_beat.data[15:8] == 8'h0)
		else $error("byte beat too wide");
	a_prefetch_load: assert property (
		s_load |=> card_beat_valid ##0 !pci_word_ready) else $error("prefetch not held");
endmodule : distributed_dma_sva

bind socket_distributed_dma_config_regs distributed_dma_sva i_distributed_dma_sva (.clk_sys, .rstn, .cfg_addr, .cfg_wdata,
	.cfg_byte_en, .cfg_write, .cfg_read, .cfg_rdata, .io_addr, .io_valid, .distributed_dma_hit,
	.distributed_dma_window_base, .card_transfer_width, .distributed_dma_decode_enable, .dma_request_pin_select,
	.pci_word_valid, .pci_word_ready, .card_beat, .card_beat_valid);

/* socket_distributed_dma_config_regs.sv */
/*
 * Distributed DMA configuration registers of a socket bridge: socket DMA control 0 and 1,
 * the head of the power management capability list, the DMA window decoder and the
 * 32-bit prefetch buffer that feeds card-side transfers.
 * Assumes all inputs are synchronous to clk_sys and the configuration master never overlaps
 * a read and a write.
 */
// Implementation choice: the address-and-strobe port.
module socket_distributed_dma_config_regs (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic [7:0] cfg_addr,
	input wire logic [31:0] cfg_wdata,
	input wire logic [3:0] cfg_byte_en,
	input wire logic cfg_write,
	input wire logic cfg_read,
	output logic [31:0] cfg_rdata,
	input wire logic [31:0] io_addr,
	input wire logic io_valid,
	output logic distributed_dma_hit,
	output logic [11:0] distributed_dma_window_base,
	output logic [1:0] card_transfer_width,
	output logic distributed_dma_decode_enable,
	output logic [1:0] dma_request_pin_select,
	input wire logic [31:0] pci_word,
	input wire logic pci_word_valid,
	output logic pci_word_ready,
	output distributed_dma_cfg_pkg::card_beat_s card_beat,
	output logic card_beat_valid,
	input wire logic card_beat_ready
);

	// ==========================================================================
	// Address decode
	// ==========================================================================
	wire logic [5:0] word_index = cfg_addr[7:2];
	wire logic hit_ctl0 = word_index == distributed_dma_cfg_pkg::socket_dma_control_0_off[7:2];
	wire logic hit_ctl1 = word_index == distributed_dma_cfg_pkg::socket_dma_control_1_off[7:2];
	wire logic hit_cap = word_index == distributed_dma_cfg_pkg::capability_identifier_off[7:2];

	distributed_dma_cfg_pkg::dma_control_1_s ctl1_reg;
	distributed_dma_cfg_pkg::dma_control_1_s ctl1_next;
	logic [1:0] pin_sel_reg;
	logic [1:0] pin_sel_next;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;

	// ==========================================================================
	// Register writes
	// ==========================================================================
	wire logic wr_ctl0 = cfg_write && hit_ctl0;
	wire logic wr_ctl1 = cfg_write && hit_ctl1;

	always_comb begin
		ctl1_next = ctl1_reg;
		pin_sel_next = pin_sel_reg;
		if (wr_ctl1 && cfg_byte_en[0]) begin
			ctl1_next.distributed_dma_window_base[3:0] = cfg_wdata[7:4];
			ctl1_next.card_transfer_width = cfg_wdata[2:1];
			ctl1_next.distributed_dma_decode_enable = cfg_wdata[0];
		end
		if (wr_ctl1 && cfg_byte_en[1]) begin
			ctl1_next.distributed_dma_window_base[11:4] = cfg_wdata[15:8];
		end
		if (wr_ctl0 && cfg_byte_en[0]) begin
			pin_sel_next = cfg_wdata[1:0];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			ctl1_reg.distributed_dma_window_base <= distributed_dma_cfg_pkg::distributed_dma_window_base_rst;
			ctl1_reg.card_transfer_width <= distributed_dma_cfg_pkg::card_transfer_width_rst;
			ctl1_reg.distributed_dma_decode_enable <= distributed_dma_cfg_pkg::distributed_dma_decode_enable_rst;
			pin_sel_reg <= distributed_dma_cfg_pkg::dma_request_pin_select_rst;
		end else begin
			ctl1_reg <= ctl1_next;
			pin_sel_reg <= pin_sel_next;
		end
	end

	// ==========================================================================
	// Register reads
	// ==========================================================================
	wire logic [31:0] ctl0_word = {30'h0, pin_sel_reg};
	wire logic [31:0] ctl1_word = {16'h0000, ctl1_reg.distributed_dma_window_base, 1'b0,
		ctl1_reg.card_transfer_width, ctl1_reg.distributed_dma_decode_enable};
	wire logic [31:0] cap_word = {16'h0000, distributed_dma_cfg_pkg::next_capability_pointer_val,
		distributed_dma_cfg_pkg::capability_identifier_val};

	always_comb begin
		rdata_next = 32'h0;
		if (cfg_read) begin
			if (hit_ctl0) begin
				rdata_next = ctl0_word;
			end else if (hit_ctl1) begin
				rdata_next = ctl1_word;
			end else if (hit_cap) begin
				rdata_next = cap_word;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			rdata_reg <= 32'h0;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	assign cfg_rdata = rdata_reg;
	assign distributed_dma_window_base = ctl1_reg.distributed_dma_window_base;
	assign card_transfer_width = ctl1_reg.card_transfer_width;
	assign distributed_dma_decode_enable = ctl1_reg.distributed_dma_decode_enable;
	assign dma_request_pin_select = pin_sel_reg;

	// ==========================================================================
	// Distributed DMA window decode
	// ==========================================================================
	wire logic upper_zero = io_addr[31:16] == 16'h0000;
	wire logic base_match = io_addr[15:4] == ctl1_reg.distributed_dma_window_base;
	assign distributed_dma_hit = io_valid && ctl1_reg.distributed_dma_decode_enable && upper_zero && base_match;

	// ==========================================================================
	// Prefetch word and card-side beats
	// ==========================================================================
	logic [31:0] prefetch_reg;
	logic [31:0] prefetch_next;
	logic full_reg;
	logic full_next;
	logic [1:0] beat_reg;
	logic [1:0] beat_next;

	wire logic wide = ctl1_reg.card_transfer_width == distributed_dma_cfg_pkg::width_16bit;
	wire logic [1:0] last_beat = wide ? distributed_dma_cfg_pkg::last_beat_16bit
		: distributed_dma_cfg_pkg::last_beat_8bit;
	wire logic beat_done = full_reg && card_beat_ready;
	wire logic word_done = beat_done && beat_reg == last_beat;
	wire logic [15:0] half_sel = beat_reg[0] ? prefetch_reg[31:16] : prefetch_reg[15:0];
	wire logic [7:0] byte_sel = prefetch_reg[8 * beat_reg +: 8];

	assign pci_word_ready = !full_reg;
	assign card_beat_valid = full_reg;
	assign card_beat = '{data: wide ? half_sel : {8'h00, byte_sel}, is_16bit: wide};

	always_comb begin
		prefetch_next = prefetch_reg;
		full_next = full_reg;
		beat_next = beat_reg;
		if (pci_word_valid && !full_reg) begin
			prefetch_next = pci_word;
			full_next = 1'b1;
			beat_next = 2'h0;
		end else if (word_done) begin
			full_next = 1'b0;
			beat_next = 2'h0;
		end else if (beat_done) begin
			beat_next = beat_reg + 2'h1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			prefetch_reg <= 32'h0;
			full_reg <= 1'b0;
			beat_reg <= 2'h0;
		end else begin
			prefetch_reg <= prefetch_next;
			full_reg <= full_next;
			beat_reg <= beat_next;
		end
	end

endmodule : socket_distributed_dma_config_regs

/* tb_top.sv */
/* Self-checking bench for the DMA configuration bank.
   Assumes the checker is bound and card_sink stands at the card side. */
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys = 1'b0;
	logic rstn = 1'b0;
	logic [7:0] cfg_addr = 8'h0;
	logic [31:0] cfg_wdata = 32'h0;
	logic [3:0] cfg_byte_en = 4'h0;
	logic cfg_write = 1'b0;
	logic cfg_read = 1'b0;
	logic [31:0] io_addr = 32'h0;
	logic io_valid = 1'b0;
	logic [31:0] pci_word = 32'h0;
	logic pci_word_valid = 1'b0;
	logic slow = 1'b0;
	logic [31:0] cfg_rdata;
	logic distributed_dma_hit;
	logic [11:0] distributed_dma_window_base;
	logic [1:0] card_transfer_width;
	logic distributed_dma_decode_enable;
	logic [1:0] dma_request_pin_select;
	logic pci_word_ready;
	logic card_beat_valid;
	logic card_beat_ready;
	distributed_dma_cfg_pkg::card_beat_s card_beat;
	int bad_count = 0;
	int n_compared = 0;
	int cyc = 0;
	logic [15:0] lf = 16'h0030;
	logic [31:0] d;
	always #25 clk_sys = ~clk_sys;
	socket_distributed_dma_config_regs i_socket_distributed_dma_config_regs (.clk_sys, .rstn, .cfg_addr, .cfg_wdata,
		.cfg_byte_en, .cfg_write, .cfg_read, .cfg_rdata, .io_addr, .io_valid, .distributed_dma_hit,
		.distributed_dma_window_base, .card_transfer_width, .distributed_dma_decode_enable,
		.dma_request_pin_select, .pci_word, .pci_word_valid, .pci_word_ready, .card_beat,
		.card_beat_valid, .card_beat_ready);
	card_sink i_card_sink (.clk_sys, .rstn, .slow, .card_beat, .card_beat_valid,
		.card_beat_ready);
	// ====================
	// Helpers.
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr
	function automatic logic [31:0] exp_ctl1(input logic [31:0] v);
		return {16'h0, v[15:4], 1'b0, v[2:0]};
	endfunction : exp_ctl1
	function automatic logic [31:0] exp_beat(input logic [31:0] w, input logic wide, input int i);
		return wide ? {16'h0, w[16*i +: 16]} : {24'h0, w[8*i +: 8]};
	endfunction : exp_beat
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			bad_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : cmp
	task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] be);
		@(posedge clk_sys);
		cfg_addr <= a;
		cfg_wdata <= v;
		cfg_byte_en <= be;
		cfg_write <= 1'b1;
		@(posedge clk_sys);
		cfg_write <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk_sys);
		cfg_addr <= a;
		cfg_read <= 1'b1;
		@(posedge clk_sys);
		cfg_read <= 1'b0;
		#1 cmp(cfg_rdata, e);
	endtask : rd
	task automatic io(input logic [31:0] a, input logic e);
		@(posedge clk_sys);
		io_addr <= a;
		io_valid <= 1'b1;
		#1 cmp({31'h0, distributed_dma_hit}, {31'h0, e});
	endtask : io
	task automatic print_verdict();
		if (bad_count == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : print_verdict
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 4000) begin
			bad_count++;
			print_verdict();
		end
	end
	// ====================
	// Stimulus.
	initial begin
		repeat (8) @(posedge clk_sys);
		rstn <= 1'b1;
		rd(8'h98, 32'h0);
		rd(8'h94, 32'h0);
		wr(8'ha0, 32'hffff_ffff, 4'hf);
		rd(8'ha1, 32'h1);
		rd(8'hfc, 32'h0);
		for (int k = 0; k < 4; k++) begin
			wr(8'h94, 32'hffff_fff0 | k, 4'hf);
			rd(8'h94, 32'(k));
			cmp({30'h0, dma_request_pin_select}, 32'(k));
		end
		for (int k = 0; k < 24; k++) begin
			lf = lfsr(lf);
			d = (k == 0) ? 32'hfff1 : (k == 1) ? 32'h1 : {~lf, lf};
			wr(8'h98, d, 4'hf);
			rd(8'h98, exp_ctl1(d));
			cmp({16'h0, distributed_dma_window_base, 1'b0, card_transfer_width, distributed_dma_decode_enable}, exp_ctl1(d));
			io({16'h0, d[15:4], lf[3:0]}, d[0]);
			io({16'h1, d[15:4], 4'h0}, 1'b0);
			io({16'h0, d[15:4] ^ 12'h1, 4'h0}, 1'b0);
		end
		wr(8'h98, 32'hffff_ab00, 4'h2);
		rd(8'h98, {16'h0, 8'hab, d[7:4], 1'b0, d[2:0]});
		for (int m = 0; m < 4; m++) begin
			slow <= m[0];
			wr(8'h98, {29'h0, m[1:0], 1'b0}, 4'h1);
			lf = lfsr(lf);
			d = {lf, ~lf};
			i_card_sink.got.delete();
			@(posedge clk_sys);
			pci_word <= d;
			pci_word_valid <= 1'b1;
			@(posedge clk_sys);
			pci_word_valid <= 1'b0;
			repeat (12) @(posedge clk_sys);
			cmp(i_card_sink.got.size(), (m == 1) ? 2 : 4);
			foreach (i_card_sink.got[i]) begin
				cmp(i_card_sink.got[i], exp_beat(d, m == 1, i));
			end
			cmp({31'h0, pci_word_ready}, 32'h1);
		end
		print_verdict();
	end
endmodule : tb_top
